/* inc/coef_bank_pkg.sv */
package coef_bank_pkg;

    // Register bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int PWR_W = 16;

    // Register indices, used directly as port addresses
    localparam logic [4:0] ROW_DOM_IDX = 5'h07;
    localparam logic [4:0] COL_DOM_IDX = 5'h08;
    localparam logic [4:0] ROW_HARM_IDX = 5'h09;
    localparam logic [4:0] COL_HARM_IDX = 5'h0a;
    localparam logic [4:0] MIN_PWR_IDX = 5'h0b;
    localparam logic [4:0] AGC_LIMIT_IDX = 5'h0c;
    localparam logic [4:0] TONE_A_FREQ_IDX = 5'h0d;
    localparam logic [4:0] TONE_A_LEVEL_IDX = 5'h0e;
    localparam logic [4:0] TONE_A_PHASE_IDX = 5'h0f;
    localparam logic [4:0] TONE_B_FREQ_IDX = 5'h10;
    localparam logic [4:0] TONE_B_LEVEL_IDX = 5'h11;
    localparam logic [4:0] TONE_B_PHASE_IDX = 5'h12;
    localparam logic [4:0] RING_DC_IDX = 5'h13;
    localparam logic [4:0] RING_FREQ_IDX = 5'h14;
    localparam logic [4:0] RING_LEVEL_IDX = 5'h15;
    localparam logic [4:0] RING_PHASE_IDX = 5'h16;
    localparam logic [4:0] METER_RAMP_IDX = 5'h17;
    localparam logic [4:0] METER_LEVEL_IDX = 5'h18;
    localparam logic [4:0] METER_FREQ_IDX = 5'h19;
    localparam logic [4:0] FIRST_IDX = ROW_DOM_IDX;
    localparam logic [4:0] LAST_IDX = METER_FREQ_IDX;

    // Ratio scaling: code for a ratio of one
    localparam logic [31:0] UNITY_RATIO = 32'h0000_07f0;
    localparam logic [31:0] SHARE_UNITY = 32'h0000_7ff0;

    // Ringing dc offset field
    localparam int RING_DC_W = 6;
    localparam int RING_DC_LSB = 0;
    localparam int RING_DC_STEP_MV = 1500;
    localparam int RING_DC_MAX_MV = 94500;

    // Oscillators holding a start phase
    localparam int OSC_N = 3;
    localparam int OSC_TONE_A = 0;
    localparam int OSC_TONE_B = 1;
    localparam int OSC_RING = 2;

    localparam logic [15:0] READ_ZERO = 16'h0000;

endpackage

/* hdl/tone_dual_tone_digit_coefficient_bank.sv */
`timescale 1ns/1ps

module tone_dual_tone_digit_coefficient_bank (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,

    // Register port
    input wire logic [coef_bank_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [coef_bank_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [coef_bank_pkg::DATA_W-1:0] reg_rdata,

    // Decoder measurements
    input wire logic eval_stb,
    input wire logic [coef_bank_pkg::PWR_W-1:0] row_peak_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] row_rest_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] row_harm_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] row_band_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] col_peak_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] col_rest_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] col_harm_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] col_band_pwr,
    input wire logic [coef_bank_pkg::PWR_W-1:0] total_pwr,
    input wire logic [coef_bank_pkg::DATA_W-1:0] row_share_thr,
    input wire logic [coef_bank_pkg::DATA_W-1:0] col_share_thr,
    input wire logic [1:0] row_idx,
    input wire logic [1:0] col_idx,

    // Decoder results
    output logic digit_valid,
    output logic [3:0] digit_code,
    output logic eval_discard,
    output logic agc_atten,

    // Oscillator control and coefficients
    input wire logic [coef_bank_pkg::OSC_N-1:0] osc_start,
    output logic signed [15:0] tone_a_frequency,
    output logic signed [15:0] tone_a_level,
    output logic signed [15:0] tone_a_phase,
    output logic signed [15:0] tone_b_frequency,
    output logic signed [15:0] tone_b_level,
    output logic signed [15:0] tone_b_phase,
    output logic [coef_bank_pkg::RING_DC_W-1:0] ringing_dc_offset,
    output logic signed [15:0] ringing_frequency,
    output logic signed [15:0] ringing_level,
    output logic signed [15:0] ringing_phase,
    output logic signed [15:0] metering_ramp_rate,
    output logic signed [15:0] metering_level,
    output logic signed [15:0] metering_frequency
);

    // Coefficient storage, no reset on purpose
    logic [15:0] bank_ff [coef_bank_pkg::LAST_IDX:coef_bank_pkg::FIRST_IDX];

    logic [15:0] rdata_ff;
    logic digit_valid_ff;
    logic [3:0] digit_code_ff;
    logic discard_ff;
    logic agc_atten_ff;
    logic [15:0] phase_ff [coef_bank_pkg::OSC_N];

    logic addr_hit;
    logic power_ok;
    logic row_dom_ok;
    logic col_dom_ok;
    logic row_harm_ok;
    logic col_harm_ok;
    logic row_share_ok;
    logic col_share_ok;
    logic all_ok;
    logic [15:0] init_phase [coef_bank_pkg::OSC_N];

    assign addr_hit = (reg_addr >= coef_bank_pkg::FIRST_IDX) &&
                      (reg_addr <= coef_bank_pkg::LAST_IDX);

    // Register writes; unused bits are stored as written
    always_ff @(posedge core_clk) begin
        if (reg_wr && addr_hit) begin
            bank_ff[reg_addr] <= reg_wdata;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= coef_bank_pkg::READ_ZERO;
        end else if (reg_rd && addr_hit) begin
            rdata_ff <= bank_ff[reg_addr];
        end else begin
            rdata_ff <= coef_bank_pkg::READ_ZERO;
        end
    end

    assign reg_rdata = rdata_ff;

    // Minimum power test, then ratio tests: power * unity against threshold * reference
    always_comb begin
        power_ok = {16'h0000, total_pwr} >=
                   {16'h0000, bank_ff[coef_bank_pkg::MIN_PWR_IDX]};
        row_dom_ok = ({16'h0000, row_peak_pwr} * coef_bank_pkg::UNITY_RATIO) >=
                     ({16'h0000, bank_ff[coef_bank_pkg::ROW_DOM_IDX]} *
                      {16'h0000, row_rest_pwr});
        col_dom_ok = ({16'h0000, col_peak_pwr} * coef_bank_pkg::UNITY_RATIO) >=
                     ({16'h0000, bank_ff[coef_bank_pkg::COL_DOM_IDX]} *
                      {16'h0000, col_rest_pwr});
        row_harm_ok = ({16'h0000, row_peak_pwr} * coef_bank_pkg::UNITY_RATIO) >=
                      ({16'h0000, bank_ff[coef_bank_pkg::ROW_HARM_IDX]} *
                       {16'h0000, row_harm_pwr});
        col_harm_ok = ({16'h0000, col_peak_pwr} * coef_bank_pkg::UNITY_RATIO) >=
                      ({16'h0000, bank_ff[coef_bank_pkg::COL_HARM_IDX]} *
                       {16'h0000, col_harm_pwr});
        row_share_ok = ({16'h0000, row_peak_pwr} * coef_bank_pkg::SHARE_UNITY) >
                       ({16'h0000, row_share_thr} * {16'h0000, row_band_pwr});
        col_share_ok = ({16'h0000, col_peak_pwr} * coef_bank_pkg::SHARE_UNITY) >
                       ({16'h0000, col_share_thr} * {16'h0000, col_band_pwr});
        all_ok = power_ok && row_dom_ok && col_dom_ok && row_harm_ok &&
                 col_harm_ok && row_share_ok && col_share_ok;
    end

    // Digit decision, one cycle after the evaluation strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            digit_valid_ff <= 1'b0;
            discard_ff <= 1'b0;
        end else begin
            digit_valid_ff <= eval_stb && all_ok;
            discard_ff <= eval_stb && !power_ok;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            digit_code_ff <= 4'h0;
        end else if (eval_stb && all_ok) begin
            digit_code_ff <= {row_idx, col_idx};
        end
    end

    // Two-step gain: attenuate when an evaluation strobe finds total power above the hot limit, held until the next strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            agc_atten_ff <= 1'b0;
        end else if (eval_stb) begin
            agc_atten_ff <= total_pwr > bank_ff[coef_bank_pkg::AGC_LIMIT_IDX];
        end
    end

    assign digit_valid = digit_valid_ff;
    assign digit_code = digit_code_ff;
    assign eval_discard = discard_ff;
    assign agc_atten = agc_atten_ff;

    // Start phase sources per oscillator
    assign init_phase[coef_bank_pkg::OSC_TONE_A] = bank_ff[coef_bank_pkg::TONE_A_PHASE_IDX];
    assign init_phase[coef_bank_pkg::OSC_TONE_B] = bank_ff[coef_bank_pkg::TONE_B_PHASE_IDX];
    assign init_phase[coef_bank_pkg::OSC_RING] = bank_ff[coef_bank_pkg::RING_PHASE_IDX];

    // Phase state reloaded on every start
    for (genvar i = 0; i < coef_bank_pkg::OSC_N; i++) begin : g_osc
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                phase_ff[i] <= 16'h0000;
            end else if (osc_start[i]) begin
                phase_ff[i] <= init_phase[i];
            end
        end
    end

    // Coefficients to the generators, all signed except the unsigned ringing dc offset field
    assign tone_a_frequency = signed'(bank_ff[coef_bank_pkg::TONE_A_FREQ_IDX]);
    assign tone_a_level = signed'(bank_ff[coef_bank_pkg::TONE_A_LEVEL_IDX]);
    assign tone_a_phase = signed'(phase_ff[coef_bank_pkg::OSC_TONE_A]);
    assign tone_b_frequency = signed'(bank_ff[coef_bank_pkg::TONE_B_FREQ_IDX]);
    assign tone_b_level = signed'(bank_ff[coef_bank_pkg::TONE_B_LEVEL_IDX]);
    assign tone_b_phase = signed'(phase_ff[coef_bank_pkg::OSC_TONE_B]);
    assign ringing_dc_offset = bank_ff[coef_bank_pkg::RING_DC_IDX]
        [coef_bank_pkg::RING_DC_LSB +: coef_bank_pkg::RING_DC_W];
    assign ringing_frequency = signed'(bank_ff[coef_bank_pkg::RING_FREQ_IDX]);
    assign ringing_level = signed'(bank_ff[coef_bank_pkg::RING_LEVEL_IDX]);
    assign ringing_phase = signed'(phase_ff[coef_bank_pkg::OSC_RING]);
    assign metering_ramp_rate = signed'(bank_ff[coef_bank_pkg::METER_RAMP_IDX]);
    assign metering_level = signed'(bank_ff[coef_bank_pkg::METER_LEVEL_IDX]);
    assign metering_frequency = signed'(bank_ff[coef_bank_pkg::METER_FREQ_IDX]);

    // Checks

    a_read_zero_unmapped: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_rd && !addr_hit) |=> (reg_rdata == 16'h0000)
    ) else $error("unmapped read returned nonzero data");

    a_readback_written: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && addr_hit) ##1 (reg_rd && reg_addr == $past(reg_addr))
        |=> (reg_rdata == $past(reg_wdata, 2))
    ) else $error("written value not read back");

    a_low_power_drop: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && total_pwr < bank_ff[coef_bank_pkg::MIN_PWR_IDX])
        |=> (eval_discard && !digit_valid)
    ) else $error("low power evaluation not discarded");

    a_row_dom_fail: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && ({16'h0000, row_peak_pwr} * 32'h0000_07f0 <
         {16'h0000, bank_ff[coef_bank_pkg::ROW_DOM_IDX]} * {16'h0000, row_rest_pwr}))
        |=> !digit_valid
    ) else $error("digit despite weak row dominance");

    a_col_dom_fail: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && ({16'h0000, col_peak_pwr} * 32'h0000_07f0 <
         {16'h0000, bank_ff[coef_bank_pkg::COL_DOM_IDX]} * {16'h0000, col_rest_pwr}))
        |=> !digit_valid
    ) else $error("digit despite weak column dominance");

    a_harmonic_fail: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && (({16'h0000, row_peak_pwr} * 32'h0000_07f0 <
          {16'h0000, bank_ff[coef_bank_pkg::ROW_HARM_IDX]} * {16'h0000, row_harm_pwr}) ||
         ({16'h0000, col_peak_pwr} * 32'h0000_07f0 <
          {16'h0000, bank_ff[coef_bank_pkg::COL_HARM_IDX]} * {16'h0000, col_harm_pwr})))
        |=> !digit_valid
    ) else $error("digit despite strong second harmonic");

    a_share_fail: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && ({16'h0000, row_peak_pwr} * 32'h0000_7ff0 <=
         {16'h0000, row_share_thr} * {16'h0000, row_band_pwr}))
        |=> !digit_valid
    ) else $error("digit despite small row band share");

    a_digit_cause: assert property (
        @(posedge core_clk) disable iff (!resetn)
        digit_valid |-> ($past(eval_stb) && digit_code == $past({row_idx, col_idx}))
    ) else $error("digit without evaluation");

    a_agc_step: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && total_pwr > bank_ff[coef_bank_pkg::AGC_LIMIT_IDX]) ##1 !eval_stb
        |-> agc_atten
    ) else $error("gain step not taken above hot limit");

    a_phase_a_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !osc_start[coef_bank_pkg::OSC_TONE_A] |=> $stable(tone_a_phase)
    ) else $error("tone A phase moved without a start");

    a_tone_b_map: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h10) |=>
        (tone_b_frequency < 0) == $past(reg_wdata[15])
    ) else $error("tone B frequency sign wrong");

    a_meter_map: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h19) |=> (metering_frequency == $past(reg_wdata))
    ) else $error("metering frequency not from location 25");

    a_ring_offset: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h13) |=> (ringing_dc_offset == $past(reg_wdata[5:0]))
    ) else $error("ringing dc offset field wrong");

    a_read_one_cycle: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !reg_rd |=> (reg_rdata == 16'h0000)
    ) else $error("read data stood beyond its cycle");

    a_tone_a_freq: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h0d) |=> (tone_a_frequency == $past(reg_wdata))
    ) else $error("tone A frequency not from location 13");

    a_tone_a_level: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h0e) |=> (tone_a_level == $past(reg_wdata))
    ) else $error("tone A level not from location 14");

    a_tone_b_level: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h11) |=> (tone_b_level == $past(reg_wdata))
    ) else $error("tone B level not from location 17");

    a_ring_freq: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h14) |=> (ringing_frequency == $past(reg_wdata))
    ) else $error("ringing frequency not from location 20");

    a_ring_level: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h15) |=> (ringing_level == $past(reg_wdata))
    ) else $error("ringing level not from location 21");

    a_meter_ramp: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h17) |=> (metering_ramp_rate == $past(reg_wdata))
    ) else $error("metering ramp rate not from location 23");

    a_meter_level: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == 5'h18) |=> (metering_level == $past(reg_wdata))
    ) else $error("metering level not from location 24");

    a_phase_a_load: assert property (
        @(posedge core_clk) disable iff (!resetn)
        osc_start[coef_bank_pkg::OSC_TONE_A] |=> (tone_a_phase == $past(bank_ff[5'h0f]))
    ) else $error("tone A phase not loaded from location 15");

    a_phase_b_load: assert property (
        @(posedge core_clk) disable iff (!resetn)
        osc_start[coef_bank_pkg::OSC_TONE_B] |=> (tone_b_phase == $past(bank_ff[5'h12]))
    ) else $error("tone B phase not loaded from location 18");

    a_ring_phase_load: assert property (
        @(posedge core_clk) disable iff (!resetn)
        osc_start[coef_bank_pkg::OSC_RING] |=> (ringing_phase == $past(bank_ff[5'h16]))
    ) else $error("ringing phase not loaded from location 22");

    a_phase_b_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !osc_start[coef_bank_pkg::OSC_TONE_B] |=> $stable(tone_b_phase)
    ) else $error("tone B phase moved without a start");

    a_ring_phase_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !osc_start[coef_bank_pkg::OSC_RING] |=> $stable(ringing_phase)
    ) else $error("ringing phase moved without a start");

    a_col_share_fail: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && ({16'h0000, col_peak_pwr} * 32'h0000_7ff0 <=
         {16'h0000, col_share_thr} * {16'h0000, col_band_pwr}))
        |=> !digit_valid
    ) else $error("digit despite small column band share");

    a_eval_quiet: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !eval_stb |=> (!digit_valid && !eval_discard)
    ) else $error("decoder result without evaluation");

    a_code_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !eval_stb |=> $stable(digit_code)
    ) else $error("digit code moved without evaluation");

    a_agc_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !eval_stb |=> $stable(agc_atten)
    ) else $error("gain step moved without evaluation");

    a_agc_below: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (eval_stb && total_pwr <= bank_ff[coef_bank_pkg::AGC_LIMIT_IDX]) |=> !agc_atten
    ) else $error("gain step taken at or below hot limit");

endmodule

/* tb/tb.sv */
`timescale 1ns/1ps

`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("ERROR %0t ns: got %h expected %h", $time, got, exp); \
    end \
end

module tb;
    logic core_clk = 1'b0;
    logic resetn, reg_wr, reg_rd, eval_stb;
    logic [coef_bank_pkg::ADDR_W-1:0] reg_addr;
    logic [coef_bank_pkg::DATA_W-1:0] reg_wdata, reg_rdata, row_share_thr, col_share_thr;
    logic [coef_bank_pkg::PWR_W-1:0] row_peak_pwr, row_rest_pwr, row_harm_pwr, row_band_pwr;
    logic [coef_bank_pkg::PWR_W-1:0] col_peak_pwr, col_rest_pwr, col_harm_pwr, col_band_pwr;
    logic [coef_bank_pkg::PWR_W-1:0] total_pwr;
    logic [1:0] row_idx, col_idx;
    logic [2:0] osc_start;
    logic digit_valid, eval_discard, agc_atten;
    logic [3:0] digit_code, last_code;
    logic signed [15:0] tone_a_frequency, tone_a_level, tone_a_phase;
    logic signed [15:0] tone_b_frequency, tone_b_level, tone_b_phase;
    logic signed [15:0] ringing_frequency, ringing_level, ringing_phase;
    logic signed [15:0] metering_ramp_rate, metering_level, metering_frequency;
    logic [5:0] ringing_dc_offset;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h4d46;
    logic [15:0] regs [32];
    logic [15:0] rd_q [$];
    logic [6:0] ev_q [$];
    logic [15:0] exp_rd;
    logic [6:0] exp_ev;
    logic [47:0] ph_exp;
    logic rd_seen = 1'b0;
    logic ev_seen = 1'b0;

    tone_dual_tone_digit_coefficient_bank i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .eval_stb, .row_peak_pwr, .row_rest_pwr, .row_harm_pwr,
        .row_band_pwr, .col_peak_pwr, .col_rest_pwr, .col_harm_pwr, .col_band_pwr, .total_pwr,
        .row_share_thr, .col_share_thr, .row_idx, .col_idx, .digit_valid, .digit_code,
        .eval_discard, .agc_atten, .osc_start, .tone_a_frequency, .tone_a_level, .tone_a_phase,
        .tone_b_frequency, .tone_b_level, .tone_b_phase, .ringing_dc_offset, .ringing_frequency,
        .ringing_level, .ringing_phase, .metering_ramp_rate, .metering_level, .metering_frequency);

    always #50 core_clk = ~core_clk;

    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    function automatic logic ratio_ok(input logic [15:0] p, q, t);
        return 32'(p) * 32'h0000_07f0 >= 32'(t) * 32'(q);
    endfunction

    task automatic bus(input logic w, r, input logic [4:0] a, input logic [15:0] d);
        logic mapped;
        mapped = a >= coef_bank_pkg::FIRST_IDX && a <= coef_bank_pkg::LAST_IDX;
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (w && mapped) regs[a] = d;
        if (r) rd_q.push_back(mapped ? regs[a] : 16'h0000);
        @(posedge core_clk);
    endtask

    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        eval_stb <= 1'b0;
        osc_start <= 3'h0;
        @(posedge core_clk);
    endtask

    // Row and column fed alike; the expected outcome is built from the stored thresholds
    task automatic ev(input logic [15:0] pk, rs, hm, bd, tot, thr, input logic [1:0] r, c);
        logic pass;
        pass = tot >= regs[11] && ratio_ok(pk, rs, regs[7]) && ratio_ok(pk, rs, regs[8])
            && ratio_ok(pk, hm, regs[9]) && ratio_ok(pk, hm, regs[10])
            && 32'(pk) * 32'h0000_7ff0 > 32'(thr) * 32'(bd);
        if (pass) last_code = {r, c};
        ev_q.push_back({pass, tot < regs[11], tot > regs[12], last_code});
        {row_peak_pwr, row_rest_pwr, row_harm_pwr, row_band_pwr} <= {pk, rs, hm, bd};
        {col_peak_pwr, col_rest_pwr, col_harm_pwr, col_band_pwr} <= {pk, rs, hm, bd};
        {total_pwr, row_share_thr, col_share_thr} <= {tot, thr, thr};
        {row_idx, col_idx, eval_stb} <= {r, c, 1'b1};
        @(posedge core_clk);
    endtask

    task wrap_up();
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Results are matched against the oldest note as they appear
    always @(posedge core_clk) begin
        if (rd_seen) begin
            exp_rd = rd_q.pop_front();
            `CHK(reg_rdata, exp_rd)
        end else if (resetn) `CHK(reg_rdata, 16'h0000)
        if (ev_seen) begin
            exp_ev = ev_q.pop_front();
            `CHK({digit_valid, eval_discard, agc_atten, digit_code}, exp_ev)
        end else if (resetn) `CHK({digit_valid, eval_discard}, 2'b00)
        rd_seen <= reg_rd;
        ev_seen <= eval_stb;
    end

    initial begin
        #(3000 * 100);
        num_errors++;
        wrap_up();
    end

    initial begin
        {resetn, reg_wr, reg_rd, eval_stb, osc_start, reg_addr, reg_wdata} = '0;
        {row_peak_pwr, row_rest_pwr, row_harm_pwr, row_band_pwr, total_pwr} = '0;
        {col_peak_pwr, col_rest_pwr, col_harm_pwr, col_band_pwr} = '0;
        {row_share_thr, col_share_thr, row_idx, col_idx, last_code} = '0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        `CHK({tone_a_phase, tone_b_phase, ringing_phase}, 48'h0)
        // Write then read each place, unmapped neighbours included
        for (int i = 5; i < 28; i++) begin
            bus(1'b1, 1'b0, 5'(i), (i == 19) ? 16'hff3f : rnd());
            bus(1'b0, 1'b1, 5'(i), 16'h0000);
        end
        bus(1'b1, 1'b0, 5'h1f, 16'hffff);
        for (int i = 0; i < 32; i++) bus(1'b0, 1'b1, 5'(i), 16'h0000);
        idle();
        `CHK({tone_a_frequency, tone_a_level}, {regs[13], regs[14]})
        `CHK({tone_b_frequency, tone_b_level}, {regs[16], regs[17]})
        `CHK(ringing_dc_offset, regs[19][5:0])
        `CHK({ringing_frequency, ringing_level}, {regs[20], regs[21]})
        `CHK({metering_ramp_rate, metering_level}, {regs[23], regs[24]})
        `CHK(metering_frequency, regs[25])
        `CHK(tone_b_level < 0, regs[17][15])
        `CHK(metering_frequency < 0, regs[25][15])
        ph_exp = '0;
        for (int k = 0; k < 3; k++) begin
            osc_start <= 3'(1 << k);
            ph_exp[16*k +: 16] = regs[(k == 0) ? 15 : (k == 1) ? 18 : 22];
            @(posedge core_clk);
            osc_start <= 3'h0;
            #1 `CHK({ringing_phase, tone_b_phase, tone_a_phase}, ph_exp)
            @(posedge core_clk);
        end
        for (int i = 7; i < 11; i++) bus(1'b1, 1'b0, 5'(i), 16'h07f0);
        bus(1'b1, 1'b0, 5'h0b, 16'h0100);
        bus(1'b1, 1'b0, 5'h0c, 16'h0200);
        idle();
        ev(16'h0100, 16'h0100, 16'h0100, 16'h0200, 16'h0100, 16'h3ff8, 2'd2, 2'd1);
        ev(16'h0100, 16'h0100, 16'h0100, 16'h01ff, 16'h0100, 16'h3ff8, 2'd2, 2'd1);
        ev(16'h0100, 16'h0100, 16'h0100, 16'h01ff, 16'h00ff, 16'h3ff8, 2'd3, 2'd3);
        ev(16'h0100, 16'h0101, 16'h0100, 16'h01ff, 16'h0201, 16'h3ff8, 2'd1, 2'd2);
        ev(16'h0100, 16'h0100, 16'h0101, 16'h01ff, 16'h0200, 16'h3ff8, 2'd0, 2'd3);
        idle();
        // Column thresholds alone raised, rows still pass
        bus(1'b1, 1'b0, 5'h08, 16'hffff);
        ev(16'h0100, 16'h0100, 16'h0100, 16'h01ff, 16'h0100, 16'h3ff8, 2'd1, 2'd1);
        idle();
        bus(1'b1, 1'b0, 5'h08, 16'h07f0);
        bus(1'b1, 1'b0, 5'h0a, 16'hffff);
        ev(16'h0100, 16'h0100, 16'h0100, 16'h01ff, 16'h0100, 16'h3ff8, 2'd1, 2'd0);
        idle();
        for (int i = 7; i < 11; i++) bus(1'b1, 1'b0, 5'(i), rnd() >> 4);
        bus(1'b1, 1'b0, 5'h0b, rnd() >> 1);
        bus(1'b1, 1'b0, 5'h0c, rnd());
        idle();
        for (int n = 0; n < 40; n++) begin
            ev(rnd() | 16'h8000, rnd() >> 4, rnd() >> 4, rnd(), rnd(), rnd() >> 2,
                2'(rnd()), 2'(rnd()));
        end
        idle();
        idle();
        `CHK(rd_q.size() + ev_q.size(), 0)
        wrap_up();
    end
endmodule
